// *** ncr_defs.vh ***
// constants shared by the nand read-side host controller
`ifndef NCR_DEFS_VH
`define NCR_DEFS_VH
// command opcodes
`define NCR_CMD_READ      8'h00
`define NCR_CMD_READ_GO   8'h30
`define NCR_CMD_CACHE_SEQ 8'h31
`define NCR_CMD_CACHE_END 8'h3f
`define NCR_CMD_COL_CHG   8'h05
`define NCR_CMD_COL_GO    8'he0
`define NCR_CMD_READ_ID   8'h90
`define NCR_CMD_PARAM     8'hec
`define NCR_CMD_STATUS    8'h70
// identification address modes
`define NCR_ID_ADDR_DEV   8'h00
`define NCR_ID_ADDR_ONFI  8'h20
`define NCR_ID_LEN_DEV    12'h005
`define NCR_ID_LEN_ONFI   12'h004
// host operation codes on the user port
`define NCR_OP_PAGE       3'h0
`define NCR_OP_CACHE_SEQ  3'h1
`define NCR_OP_CACHE_RND  3'h2
`define NCR_OP_CACHE_END  3'h3
`define NCR_OP_COL        3'h4
`define NCR_OP_ID         3'h5
`define NCR_OP_PARAM      3'h6
// status bit positions and patterns
`define NCR_SR_CACHE_RDY  6
`define NCR_SR_ARRAY_RDY  5
`define NCR_SR_SEQ_DONE   2'b10
`define NCR_SR_END_DONE   2'b11
// strobe timing, ns, and cycles at 200 MHz (5 ns)
`define NCR_CLK_NS        5
`define NCR_STROBE_NS     25
// cycle counts sized to the 8-bit phase timer; a load of n holds a phase n+1 cycles
`define NCR_STROBE_CYC    8'h05
`define NCR_WB_NS         100
`define NCR_WB_CYC        8'h14
`endif

// *** ncr_fifo.v ***
// synchronous fifo carrying read bytes to the user
`timescale 1ns/1ps
module ncr_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 32,
	parameter AW    = 5
) (
	input  wire             clk,
	input  wire             rst_b,
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output wire             in_ready,
	output reg  [WIDTH-1:0] out_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire             empty_o
);
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];  // storage
	reg [AW:0]      wp_q;               // write pointer with wrap bit
	reg [AW:0]      rp_q;               // read pointer with wrap bit
	wire            full;
	wire            empty;
	wire            push;
	wire            pop;
	assign full     = (wp_q[AW-1:0] == rp_q[AW-1:0]) && (wp_q[AW] != rp_q[AW]);
	assign empty    = (wp_q == rp_q);
	assign in_ready = ~full;
	assign out_valid = ~empty;
	assign empty_o  = empty;
	assign push     = in_valid & ~full;
	assign pop      = out_ready & ~empty;
	// -----------------------------
	// pointers
	// -----------------------------
	always @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wp_q <= {(AW+1){1'b0}};
			rp_q <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wp_q <= wp_q + 1'b1;
			if (pop)
				rp_q <= rp_q + 1'b1;
		end
	end
	// storage has no reset; head word read through
	always @(posedge clk)
	begin
		if (push)
			mem_q[wp_q[AW-1:0]] <= in_data;
	end
	always @*
	begin
		out_data = mem_q[rp_q[AW-1:0]];
	end
endmodule // ncr_fifo

// *** ncr_host.v ***
// nand host controller for page, cache, id and parameter reads
`timescale 1ns/1ps
`include "ncr_defs.vh"
// Notes on behaviour
// - random cache: 00h, four addresses, 31h
// - column change: 05h, two columns, e0h
// - column change only after page or parameter read
// - id read: 90h, 00h or 20h, five or four bytes
// - cache read starts after page or parameter read
module ncr_host #(
	parameter NBYTES = 12'd2048     // bytes fetched per non-id op when req_len is zero
) (
	input  wire        sys_clk,
	input  wire        rst_b,
	// user request port
	input  wire        req_valid,
	output wire        req_ready,
	input  wire [2:0]  req_op,
	input  wire [31:0] req_addr,    // col[15:0], row[31:16]
	input  wire [11:0] req_len,     // bytes to read outside id reads, zero uses NBYTES
	output reg         done_q,      // pulse at operation end
	output reg  [1:0]  last_sr_q,   // status bits 6:5 after busy
	// read data out
	output wire [7:0]  rd_data,
	output wire        rd_valid,
	input  wire        rd_ready,
	// nand pins
	output reg         cle_q,
	output reg         ale_q,
	output reg         ce_n_q,
	output reg         we_n_q,
	output reg         read_strobe_n_q,
	output reg  [7:0]  io_out_q,
	output reg         io_oe_q,
	input  wire [7:0]  io_in,
	input  wire        ready_busy_n
);
	// -----------------------------
	// reset release
	// -----------------------------
	reg rs1_q;
	reg rst_sync_b;
	always @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rs1_q      <= 1'b0;
			rst_sync_b <= 1'b0;
		end
		else
		begin
			rs1_q      <= 1'b1;
			rst_sync_b <= rs1_q;
		end
	end
	// states
	localparam ST_IDLE = 3'd0;
	localparam ST_PIN  = 3'd1;  // one write cycle on the pins
	localparam ST_NEXT = 3'd2;  // pick next pin step
	localparam ST_WAIT = 3'd3;  // wait for ready
	localparam ST_SR   = 3'd4;  // status readout
	localparam ST_DATA = 3'd5;  // data strobes
	reg [2:0]  st_q;
	reg [2:0]  op_q;             // current op
	reg [3:0]  step_q;           // index into op script
	reg [7:0]  cnt_q;            // pin phase timer
	reg        ph_q;             // strobe low / high phase
	reg [11:0] left_q;           // bytes still to read
	reg [31:0] addr_q;           // latched address
	reg        loaded_q;         // a page sits in the cache
	reg        wr_kind_q;        // 1 command, 0 address
	reg [7:0]  wr_byte_q;        // byte to write
	wire       fifo_in_ready;
	wire       fifo_empty;
	reg        push_q;
	reg  [7:0] push_data_q;
	assign req_ready = (st_q == ST_IDLE) & rst_sync_b;
	// -----------------------------
	// op scripts: step -> byte and kind, scr_end ends
	// -----------------------------
	reg [8:0] scr;  // {kind, byte}: bit 8 is 1 for command, 0 for address
	reg       scr_end;
	always @*
	begin
		scr     = 9'h000;
		scr_end = 1'b0;
		case (op_q)
		`NCR_OP_PAGE:
			case (step_q)
			4'd0: scr = {1'b1, `NCR_CMD_READ};
			4'd1: scr = {1'b0, addr_q[7:0]};
			4'd2: scr = {1'b0, addr_q[15:8]};
			4'd3: scr = {1'b0, addr_q[23:16]};
			4'd4: scr = {1'b0, addr_q[31:24]};
			4'd5: scr = {1'b1, `NCR_CMD_READ_GO};
			default: scr_end = 1'b1;
			endcase
		`NCR_OP_CACHE_SEQ:
			case (step_q)
			4'd0: scr = {1'b1, `NCR_CMD_CACHE_SEQ};
			default: scr_end = 1'b1;
			endcase
		`NCR_OP_CACHE_RND:
			case (step_q)
			4'd0: scr = {1'b1, `NCR_CMD_READ};
			4'd1: scr = {1'b0, 8'h00};
			4'd2: scr = {1'b0, 8'h00};
			4'd3: scr = {1'b0, addr_q[23:16]};
			4'd4: scr = {1'b0, addr_q[31:24]};
			4'd5: scr = {1'b1, `NCR_CMD_CACHE_SEQ};
			default: scr_end = 1'b1;
			endcase
		`NCR_OP_CACHE_END:
			case (step_q)
			4'd0: scr = {1'b1, `NCR_CMD_CACHE_END};
			default: scr_end = 1'b1;
			endcase
		`NCR_OP_COL:
			case (step_q)
			4'd0: scr = {1'b1, `NCR_CMD_COL_CHG};
			4'd1: scr = {1'b0, addr_q[7:0]};
			4'd2: scr = {1'b0, addr_q[15:8]};
			4'd3: scr = {1'b1, `NCR_CMD_COL_GO};
			default: scr_end = 1'b1;
			endcase
		`NCR_OP_ID:
			case (step_q)
			4'd0: scr = {1'b1, `NCR_CMD_READ_ID};
			4'd1: scr = {1'b0, addr_q[7:0]};
			default: scr_end = 1'b1;
			endcase
		`NCR_OP_PARAM:
			case (step_q)
			4'd0: scr = {1'b1, `NCR_CMD_PARAM};
			4'd1: scr = {1'b0, 8'h00};
			default: scr_end = 1'b1;
			endcase
		default: scr_end = 1'b1;
		endcase
	end
	// ops that go busy
	wire op_busy = (op_q == `NCR_OP_PAGE) | (op_q == `NCR_OP_CACHE_SEQ) | (op_q == `NCR_OP_CACHE_RND) |
	               (op_q == `NCR_OP_CACHE_END) | (op_q == `NCR_OP_PARAM);
	wire [11:0] id_len = (addr_q[7:0] == `NCR_ID_ADDR_ONFI) ? `NCR_ID_LEN_ONFI : `NCR_ID_LEN_DEV;
	// -----------------------------
	// main sequencer
	// -----------------------------
	always @(posedge sys_clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			st_q <= ST_IDLE;
			op_q <= 3'h0;
			step_q <= 4'h0;
			cnt_q <= 8'h00;
			ph_q <= 1'b0;
			left_q <= 12'h000;
			addr_q <= 32'h0;
			loaded_q <= 1'b0;
			wr_kind_q <= 1'b0;
			wr_byte_q <= 8'h00;
			done_q <= 1'b0;
			last_sr_q <= 2'b00;
			cle_q <= 1'b0;
			ale_q <= 1'b0;
			ce_n_q <= 1'b1;
			we_n_q <= 1'b1;
			read_strobe_n_q <= 1'b1;
			io_out_q <= 8'h00;
			io_oe_q <= 1'b0;
			push_q <= 1'b0;
			push_data_q <= 8'h00;
		end
		else
		begin
			done_q <= 1'b0;
			push_q <= 1'b0;
			case (st_q)
			ST_IDLE:
				if (req_valid)
				begin
					op_q   <= req_op;
					addr_q <= req_addr;
					step_q <= 4'h0;
					ce_n_q <= 1'b0;
					left_q <= (req_len == 12'h000) ? NBYTES : req_len;
					// column change and cache ops both need an earlier page or parameter read
					if (((req_op == `NCR_OP_COL) | (req_op == `NCR_OP_CACHE_SEQ) |
					     (req_op == `NCR_OP_CACHE_RND) | (req_op == `NCR_OP_CACHE_END)) & ~loaded_q)
					begin
						done_q <= 1'b1;
						ce_n_q <= 1'b1;
					end
					else
						st_q <= ST_NEXT;
				end
			ST_NEXT:
				if (scr_end)
				begin
					cnt_q <= `NCR_WB_CYC;
					// last pin step leaves ph_q high; data phase must start with a strobe
					ph_q  <= 1'b0;
					st_q  <= op_busy ? ST_WAIT : ST_DATA;
					if (op_q == `NCR_OP_ID)
						left_q <= id_len;
				end
				else
				begin
					// strobe write of one command or address byte
					cle_q    <= scr[8];
					ale_q    <= ~scr[8];
					io_out_q <= scr[7:0];
					io_oe_q  <= 1'b1;
					we_n_q   <= 1'b0;
					ph_q     <= 1'b0;
					cnt_q    <= `NCR_STROBE_CYC;
					st_q     <= ST_PIN;
				end
			ST_PIN:
				if (cnt_q != 8'h00)
					cnt_q <= cnt_q - 8'h01;
				else if (!ph_q)
				begin
					we_n_q <= 1'b1;
					ph_q   <= 1'b1;
					cnt_q  <= `NCR_STROBE_CYC;
				end
				else
				begin
					cle_q   <= 1'b0;
					ale_q   <= 1'b0;
					io_oe_q <= 1'b0;
					step_q  <= step_q + 4'h1;
					st_q    <= ST_NEXT;
				end
			ST_WAIT:
				if (cnt_q != 8'h00)
					cnt_q <= cnt_q - 8'h01;
				else if (ready_busy_n)
				begin
					// read status to see bits 6:5
					cle_q    <= 1'b1;
					io_out_q <= `NCR_CMD_STATUS;
					io_oe_q  <= 1'b1;
					we_n_q   <= 1'b0;
					ph_q     <= 1'b0;
					cnt_q    <= `NCR_STROBE_CYC;
					st_q     <= ST_SR;
				end
			ST_SR:
				if (cnt_q != 8'h00)
					cnt_q <= cnt_q - 8'h01;
				else if (!ph_q)
				begin
					// cle held past the write edge so the command latches cleanly
					we_n_q <= 1'b1;
					ph_q   <= 1'b1;
					cnt_q  <= `NCR_STROBE_CYC;
				end
				else if (read_strobe_n_q)
				begin
					// command latched; turn the bus round and strobe out status
					cle_q           <= 1'b0;
					io_oe_q         <= 1'b0;
					read_strobe_n_q <= 1'b0;
					cnt_q           <= `NCR_STROBE_CYC;
				end
				else
				begin
					// record cache and array ready bits
					last_sr_q <= {io_in[`NCR_SR_CACHE_RDY], io_in[`NCR_SR_ARRAY_RDY]};
					read_strobe_n_q <= 1'b1;
					loaded_q <= 1'b1;
					ph_q     <= 1'b0;
					// status mode sticks, so every busy op re-seats the column before data
					step_q <= 4'h0;
					op_q   <= `NCR_OP_COL;
					addr_q <= (op_q == `NCR_OP_PAGE) ? addr_q : 32'h0;
					st_q   <= ST_NEXT;
				end
			ST_DATA:
				if (left_q == 12'h000)
				begin
					done_q <= 1'b1;
					ce_n_q <= 1'b1;
					st_q   <= ST_IDLE;
				end
				else if (cnt_q != 8'h00)
					cnt_q <= cnt_q - 8'h01;
				else if (!ph_q)
				begin
					if (fifo_in_ready)
					begin
						read_strobe_n_q <= 1'b0;
						ph_q  <= 1'b1;
						cnt_q <= `NCR_STROBE_CYC;
					end
				end
				else
				begin
					read_strobe_n_q <= 1'b1;
					push_q      <= 1'b1;
					push_data_q <= io_in;
					left_q      <= left_q - 12'h001;
					ph_q        <= 1'b0;
					cnt_q       <= `NCR_STROBE_CYC;
				end
			default: st_q <= ST_IDLE;
			endcase
		end
	end
	// parameter content is checked by the user from the byte stream
	// -----------------------------
	// output buffer
	// -----------------------------
	ncr_fifo #(
		.WIDTH (8),
		.DEPTH (32),
		.AW    (5)
	) u_fifo (
		.clk       (sys_clk),
		.rst_b     (rst_sync_b),
		.in_data   (push_data_q),
		.in_valid  (push_q),
		.in_ready  (fifo_in_ready),
		.out_data  (rd_data),
		.out_valid (rd_valid),
		.out_ready (rd_ready),
		.empty_o   (fifo_empty)
	);
endmodule // ncr_host

// *** ncr_host_properties.sv ***
// assertions on the ports of the nand host controller
`timescale 1ns/1ps
module ncr_host_props #(
	parameter NBYTES = 12'd2048
) (
	input wire       sys_clk,
	input wire       rst_b,
	input wire       req_valid,
	input wire       req_ready,
	input wire [2:0] req_op,
	input wire       done_q,
	input wire [1:0] last_sr_q,
	input wire       ce_n_q,
	input wire       cle_q,
	input wire       ale_q,
	input wire       we_n_q,
	input wire       read_strobe_n_q,
	input wire       io_oe_q,
	input wire       ready_busy_n
);
reg [2:0] op_q; // op of the request in flight
reg       ld_q; // a page or parameter read has completed
// ----------------------------------------
// request tracking
// ----------------------------------------
always @(posedge sys_clk or negedge rst_b)
begin
	if (!rst_b)
	begin
		op_q <= 3'h0;
		ld_q <= 1'b0;
	end
	else
	begin
		if (req_valid && req_ready)
			op_q <= req_op;
		if (done_q && (op_q == 3'h0 || op_q == 3'h6))
			ld_q <= 1'b1;
	end
end
default clocking cb @(posedge sys_clk); endclocking
default disable iff (!rst_b);
sequence s_early;
	req_valid && req_ready && !ld_q && req_op >= 3'h1 && req_op <= 3'h4;
endsequence
sequence s_quiet_done;
	##[1:3] done_q;
endsequence
chk_refused_quiet: assert property (s_early |-> (we_n_q && read_strobe_n_q) throughout s_quiet_done)
	else $error("refused op moved pins");
chk_cache_status: assert property (done_q && ld_q && (op_q == 3'h1 || op_q == 3'h2) |-> last_sr_q == 2'b10)
	else $error("cache status not 10");
chk_end_status: assert property (done_q && ld_q && op_q == 3'h3 |-> last_sr_q == 2'b11)
	else $error("last cache status not 11");
chk_page_status: assert property (done_q && op_q == 3'h0 |-> last_sr_q == 2'b11)
	else $error("page status not 11");
chk_strobe_low: assert property ($fell(read_strobe_n_q) |-> (!read_strobe_n_q)[*5])
	else $error("read strobe too short");
chk_we_low: assert property ($fell(we_n_q) |-> (!we_n_q)[*5])
	else $error("write strobe too short");
chk_strobe_ready: assert property ($fell(read_strobe_n_q) |-> ready_busy_n)
	else $error("read strobe while busy");
chk_busy_quiet: assert property (!ready_busy_n |-> we_n_q && read_strobe_n_q)
	else $error("pin activity while busy");
chk_bus_dir: assert property (!read_strobe_n_q |-> !io_oe_q)
	else $error("host drives bus during read");
chk_latch_excl: assert property (!(cle_q && ale_q))
	else $error("command and address latch together");
chk_ce_strobe: assert property ((!we_n_q || !read_strobe_n_q) |-> !ce_n_q)
	else $error("strobe without chip enable");
endmodule // ncr_host_props
bind ncr_host ncr_host_props #(.NBYTES(NBYTES)) u_props (.sys_clk(sys_clk), .rst_b(rst_b),
	.req_valid(req_valid), .req_ready(req_ready), .req_op(req_op), .done_q(done_q),
	.last_sr_q(last_sr_q), .ce_n_q(ce_n_q), .cle_q(cle_q), .ale_q(ale_q), .we_n_q(we_n_q),
	.read_strobe_n_q(read_strobe_n_q), .io_oe_q(io_oe_q), .ready_busy_n(ready_busy_n));

// *** ncr_dev_model.sv ***
// behavioural nand device answering the host controller
`timescale 1ns/1ps
module ncr_dev_model #(
	parameter [39:0] ID5     = 40'h1122334455, // arbitrary identity bytes
	parameter        BUSY_NS = 300             // short stand-in for busy times
) (
	input  wire       ce_n,
	input  wire       cle,
	input  wire       ale,
	input  wire       we_n,
	input  wire       re_n,
	input  wire [7:0] din,
	output reg  [7:0] dout,
	output reg        rb
);
reg [7:0]  cmd_q = 8'h00;  // last command
reg [1:0]  na = 2'h0;      // address cycle count
reg [15:0] col = 16'h0000; // output column
reg [15:0] row = 16'h0000; // row from address
reg [15:0] dr_row = 16'h0000; // page in data register
reg [15:0] cr_row = 16'h0000; // page in cache register
reg [1:0]  sr = 2'b11;     // status bits 6:5
reg [1:0]  nsr = 2'b11;    // status after busy
reg [1:0]  mode = 2'h0;    // 0 data 1 id 2 param 3 status
reg [1:0]  dmode = 2'h0;   // mode after status
reg [7:0]  ida = 8'h00;    // id address byte
event      kick;           // starts a busy phase
initial rb = 1'b1;
initial dout = 8'h00;
// copies every 256, low byte first
function [7:0] pbyte(input [15:0] c);
	case (c[7:0])
		8'h00: pbyte = 8'h4f;
		8'h01: pbyte = 8'h4e;
		8'h02: pbyte = 8'h46;
		8'h03: pbyte = 8'h49;
		8'h51: pbyte = 8'h08;
		8'h54: pbyte = 8'h40;
		8'h57: pbyte = 8'h02;
		8'h5a: pbyte = 8'h10;
		8'h5c: pbyte = 8'h40;
		8'h61: pbyte = 8'h04;
		8'h64: pbyte = 8'h01;
		8'h65: pbyte = 8'h22;
		8'h6e: pbyte = 8'h04;
		8'h85: pbyte = 8'hbc;
		8'h86: pbyte = 8'h02;
		8'h87: pbyte = 8'h10;
		8'h88: pbyte = 8'h27;
		8'h89: pbyte = 8'h19;
		default: pbyte = 8'h00;
	endcase
endfunction
function [7:0] dbyte();
	case (mode)
		2'h0: dbyte = cr_row[7:0] + col[7:0];
		2'h1: dbyte = (ida == 8'h20) ? 32'h4f4e4649 >> (5'd24 - {col[1:0], 3'b000}) : ID5 >> (6'd32 - {col[2:0], 3'b000});
		2'h2: dbyte = pbyte(col);
		default: dbyte = {1'b1, sr, 5'h00};
	endcase
endfunction
// busy then status, pin follows bit 6
always @(kick)
begin
	// odd offset keeps pin changes off the host's clock edges
	#22 rb = 1'b0;
	sr = 2'b00;
	#(BUSY_NS) sr = nsr;
	rb = nsr[1];
end
always @(posedge we_n)
begin
	if (!ce_n && cle)
	begin
		// cache moves, random takes row only
		if (din == 8'h31 || din == 8'h3f)
		begin
			cr_row = dr_row;
			dr_row = (din == 8'h3f) ? dr_row : (cmd_q == 8'h00) ? row : dr_row + 16'h0001;
			nsr = (din == 8'h3f) ? 2'b11 : 2'b10;
			col = 16'h0000;
			-> kick;
		end
		if (din == 8'h30)
		begin
			dr_row = row;
			cr_row = row;
			nsr = 2'b11;
			-> kick;
		end
		// read modes hold until the next 90h, ech or 00h command
		if (din == 8'h90 || din == 8'hec || din == 8'h00)
			dmode = (din == 8'h90) ? 2'h1 : (din == 8'hec) ? 2'h2 : 2'h0;
		mode = (din == 8'h70) ? 2'h3 : dmode;
		na = 2'h0;
		cmd_q = din;
	end
	if (!ce_n && ale)
	begin
		case (na)
			2'h0: col[7:0] = din;
			2'h1: col[15:8] = din;
			2'h2: row[7:0] = din;
			default: row[15:8] = din;
		endcase
		na = na + 2'h1;
		if (cmd_q == 8'h90 || cmd_q == 8'hec)
		begin
			ida = din;
			col = 16'h0000;
			nsr = 2'b11;
			if (cmd_q == 8'hec)
				-> kick;
		end
	end
end
always @(negedge re_n)
	if (!ce_n)
		dout = dbyte();
// column advances per strobe except in status mode; bus garbled after hold
always @(posedge re_n)
begin
	if (mode != 2'h3)
		col = col + 16'h0001;
	#2 dout = ~dout;
end
endmodule // ncr_dev_model

// *** ncr_host_tb.sv ***
// self-checking bench for the nand host controller
`timescale 1ns/1ps
module ncr_host_tb;
localparam [39:0] ID5 = 40'h1122334455; // arbitrary identity bytes
reg         sys_clk = 1'b0;
reg         rst_b = 1'b0;
reg         req_valid = 1'b0;
reg  [2:0]  req_op = 3'h0;
reg  [31:0] req_addr = 32'h00000000;
reg  [11:0] req_len = 12'h000;
reg         rd_ready = 1'b0;
wire        req_ready, done_q, rd_valid, cle_q, ale_q, ce_n_q, we_n_q, read_strobe_n_q, io_oe_q, rb;
wire [1:0]  last_sr_q;
wire [7:0]  rd_data, io_out_q, io_in;
integer     errors = 0;
integer     n_tests = 0;
integer     cyc = 0;
reg  [7:0]  got [$];
reg  [7:0]  erow;
always #2.5 sys_clk = ~sys_clk;
ncr_host #(.NBYTES(12'd2048)) uut (.sys_clk(sys_clk), .rst_b(rst_b), .req_valid(req_valid),
	.req_ready(req_ready), .req_op(req_op), .req_addr(req_addr), .req_len(req_len), .done_q(done_q),
	.last_sr_q(last_sr_q), .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready), .cle_q(cle_q),
	.ale_q(ale_q), .ce_n_q(ce_n_q), .we_n_q(we_n_q), .read_strobe_n_q(read_strobe_n_q),
	.io_out_q(io_out_q), .io_oe_q(io_oe_q), .io_in(io_in), .ready_busy_n(rb));
ncr_dev_model #(.ID5(ID5)) dev (.ce_n(ce_n_q), .cle(cle_q), .ale(ale_q), .we_n(we_n_q),
	.re_n(read_strobe_n_q), .din(io_out_q), .dout(io_in), .rb(rb));
task tally_and_finish;
begin
	$display("comparisons %0d mismatches %0d", n_tests, errors);
	if (errors == 0 && n_tests > 0)
		$display("ALL CHECKS OK");
	else
		$display("CHECKS NOT OK");
	$finish;
end
endtask
// hang guard, far above the expected run
always @(posedge sys_clk)
begin
	cyc = cyc + 1;
	if (cyc == 60000)
	begin
		errors = errors + 1;
		tally_and_finish;
	end
end
task chk(input string nm, input [7:0] e, input [7:0] g);
begin
	n_tests = n_tests + 1;
	if (g !== e)
	begin
		errors = errors + 1;
		$display("mismatch %0s expected %h seen %h", nm, e, g);
	end
end
endtask
// one request, collecting bytes; stall holds the fifo output
task run(input [2:0] op, input [31:0] a, input [11:0] n, input integer stall);
	integer k;
	reg     dn;
begin
	got.delete();
	dn = 1'b0;
	k = 0;
	req_valid <= 1'b1;
	req_op <= op;
	req_addr <= a;
	req_len <= n;
	rd_ready <= 1'b0;
	@(posedge sys_clk);
	while (req_ready !== 1'b1)
		@(posedge sys_clk);
	req_valid <= 1'b0;
	while (!(dn && rd_valid !== 1'b1))
	begin
		@(posedge sys_clk);
		k = k + 1;
		if (rd_valid === 1'b1 && rd_ready)
			got.push_back(rd_data);
		if (done_q === 1'b1)
			dn = 1'b1;
		rd_ready <= (k >= stall);
	end
end
endtask
// kind 0 page data, 1 id, 2 parameter page, 3 onfi signature
task cmpq(input [1:0] kind, input [15:0] b, input integer n);
	integer   i;
	reg [7:0] e;
begin
	chk("count", n[7:0], got.size());
	for (i = 0; i < n; i = i + 1)
	begin
		case (kind)
			2'd0: e = erow + b[7:0] + i[7:0];
			2'd1: e = ID5[39 - 8 * i -: 8];
			2'd2: e = dev.pbyte(b + i[15:0]);
			default: e = 32'h4f4e4649 >> (24 - 8 * i);
		endcase
		chk("byte", e, (i < got.size()) ? got[i] : 8'hxx);
	end
end
endtask
task t_refused;
begin
	run(3'h1, 32'h00000000, 12'h004, 0);
	cmpq(2'd0, 16'h0000, 0);
	$display("test refused ended");
end
endtask
task t_page;
begin
	erow = 8'h05;
	run(3'h0, {16'h0005, 16'h0003}, 12'h004, 0);
	cmpq(2'd0, 16'h0003, 4);
	chk("status", 8'h03, {6'h00, last_sr_q});
	$display("test page ended");
end
endtask
task t_cache;
begin
	run(3'h1, 32'h00000000, 12'h004, 0);
	cmpq(2'd0, 16'h0000, 4);
	chk("status", 8'h02, {6'h00, last_sr_q});
	erow = 8'h06;
	run(3'h1, 32'h00000000, 12'h004, 0);
	cmpq(2'd0, 16'h0000, 4);
	erow = 8'h07;
	run(3'h2, {16'h0009, 16'h0033}, 12'h004, 0);
	cmpq(2'd0, 16'h0000, 4);
	erow = 8'h09;
	run(3'h3, 32'h00000000, 12'h004, 0);
	cmpq(2'd0, 16'h0000, 4);
	chk("status", 8'h03, {6'h00, last_sr_q});
	run(3'h4, 32'h0000000a, 12'h003, 0);
	cmpq(2'd0, 16'h000a, 3);
	$display("test cache ended");
end
endtask
task t_id;
begin
	run(3'h5, 32'h00000000, 12'h000, 0);
	cmpq(2'd1, 16'h0000, 5);
	run(3'h5, 32'h00000020, 12'h000, 0);
	cmpq(2'd3, 16'h0000, 4);
	$display("test id ended");
end
endtask
task t_param;
begin
	run(3'h6, 32'h00000000, 12'h004, 0);
	cmpq(2'd2, 16'h0000, 4);
	run(3'h4, 32'h00000050, 12'h028, 600);
	cmpq(2'd2, 16'h0050, 40);
	run(3'h4, 32'h00000085, 12'h006, 0);
	cmpq(2'd2, 16'h0085, 6);
	run(3'h4, 32'h00000150, 12'h004, 0);
	cmpq(2'd2, 16'h0150, 4);
	$display("test param ended");
end
endtask
initial
begin
	repeat (3) @(posedge sys_clk);
	rst_b <= 1'b1;
	repeat (4) @(posedge sys_clk);
	t_refused;
	t_page;
	t_cache;
	t_id;
	t_param;
	tally_and_finish;
end
endmodule // ncr_host_tb
